// *** logic/asc_pkg.sv ***
// Package for the serial control port of the 12-bit converter
package asc_pkg;

   // ***************************************************
   // Control word layout
   // ***************************************************
   localparam int CW_WIDTH      = 8;
   localparam int RES_WIDTH     = 12;
   localparam int BIT_START     = 7;
   localparam int BIT_SPAN      = 6;
   localparam int BIT_POLARITY  = 5;
   localparam int BIT_PWR_N     = 4;
   localparam int BIT_DEPTH     = 3;
   localparam int BIT_TIMING    = 2;
   localparam int BIT_REF       = 0;

   // ***************************************************
   // Sequence counts, in shift clock cycles
   // ***************************************************
   localparam logic [4:0] ACQ_CYCLE    = 5'h04; // Tracking begins after this cycle
   localparam logic [4:0] HOLD_CYCLE   = 5'h08; // Hold and convert after this cycle
   localparam logic [4:0] RESTART_BITS = 5'h08; // Output bits sent before restart: D4 is eighth
   localparam logic [4:0] BIT_CNT_RST  = 5'h00;

   // Reset values: normal operation, external reference
   localparam logic [7:0] CW_RESET  = 8'h10;
   localparam logic [11:0] RES_RESET = 12'h000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WORD,
      ST_CONV
   } asc_state_type;

   // Settings decoded from the control word
   typedef struct packed {
      logic span_select;
      logic polarity_select;
      logic power_down_n;
      logic shutdown_depth;
      logic shutdown_timing;
      logic ref_internal;
   } asc_cfg_type;

   // Status of the analog core
   typedef struct packed {
      logic tracking;
      logic converting;
      logic light_sleep;
      logic deep_sleep;
   } asc_core_type;

endpackage

// *** logic/asc_port.sv ***
// Serial control and readout port of the 12-bit successive-approximation converter
`timescale 1ns/1ps
// How it works
// - Serial input is sampled on each rising shift clock edge.
// - Serial output changes on each falling shift clock edge.
// - Output driven only while chip select is low, else released.
// - Shift clock alone paces transfers and conversion steps.
// - Tracking starts at the falling edge of word cycle four.
// - Hold and conversion start at the falling edge of word cycle eight.
// - Each conversion yields a 12-bit successive-approximation result.
// - Bit 6 picks the smaller or larger input span.
// - Bit 5 picks unipolar or bipolar conversion.
// - Bit 4 low requests power-down, high keeps normal operation.
// - Bit 2 picks delayed or immediate power-down entry.
// - Bit 0 enables the internal reference buffer; default is external.
// - Start is first high bit when idle or after output bit 4.
// - Twelve result bits follow MSB first, then zeros.
// - Unipolar result is straight binary, bipolar is two's complement.
// - Bits 3:2 decode into four standby or full, delayed or immediate modes.
module asc_port #(
   parameter int RES_BITS = asc_pkg::RES_WIDTH
) (
   input  wire logic                CLK,
   input  wire logic                RSTN,
   input  wire logic                SHIFT_CLK,
   input  wire logic                CHIP_SEL_N,
   input  wire logic                SER_IN,
   input  wire logic                CMP_ABOVE,
   output logic                     SER_OUT,
   output logic                     SER_OUT_OE,
   output logic [RES_BITS-1:0]      SAR_TRIAL,
   output asc_pkg::asc_cfg_type     CFG,
   output asc_pkg::asc_core_type    CORE
);

   // ***************************************************
   // Shift clock edge detection
   // ***************************************************
   // Pins are taken as synchronous to CLK, so one stage of history is enough
   logic                       sclk_ff;
   logic                       rise;
   logic                       fall;
   logic                       sel;
   assign rise = SHIFT_CLK & ~sclk_ff;
   assign fall = ~SHIFT_CLK & sclk_ff;
   assign sel  = ~CHIP_SEL_N;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) sclk_ff <= 1'b0;
      else       sclk_ff <= SHIFT_CLK;
   end

   // ***************************************************
   // State, counters and data registers
   // ***************************************************
   asc_pkg::asc_state_type     state_ff;
   asc_pkg::asc_state_type     nxt_state;
   logic [4:0]                 cnt_ff;
   logic [4:0]                 nxt_cnt;
   logic [7:0]                 word_ff;
   logic [7:0]                 nxt_word;
   logic [RES_BITS-1:0]        trial_ff;
   logic [RES_BITS-1:0]        nxt_trial;
   logic [RES_BITS-1:0]        mask_ff;
   logic [RES_BITS-1:0]        nxt_mask;
   logic                       out_ff;
   logic                       nxt_out;
   logic                       oe_ff;
   asc_pkg::asc_cfg_type       cfg_ff;
   asc_pkg::asc_cfg_type       nxt_cfg;
   asc_pkg::asc_core_type      core_ff;
   asc_pkg::asc_core_type      nxt_core;

   // Decisions use the comparator against the trial value under test
   logic                       start_ok;
   logic                       word_done;
   logic                       acq_edge;
   logic [7:0]                 full_word;
   logic                       imm_pd;
   logic                       dec_bit;
   logic [RES_BITS-1:0]        kept_trial;

   // Restart allowed when idle, or once output bit 4 has left the port
   assign start_ok   = (state_ff == asc_pkg::ST_IDLE) ||
                       (state_ff == asc_pkg::ST_CONV && cnt_ff >= asc_pkg::RESTART_BITS);
   assign acq_edge   = (state_ff == asc_pkg::ST_WORD) && (cnt_ff == asc_pkg::ACQ_CYCLE);
   assign word_done  = (state_ff == asc_pkg::ST_WORD) && (cnt_ff == asc_pkg::HOLD_CYCLE);
   assign full_word  = word_ff;
   assign imm_pd     = ~full_word[asc_pkg::BIT_PWR_N] & full_word[asc_pkg::BIT_TIMING];
   // Bipolar codes flip the top decision so the result reads two's complement
   assign dec_bit    = CMP_ABOVE ^ (cfg_ff.polarity_select && mask_ff[RES_BITS-1]);
   assign kept_trial = CMP_ABOVE ? trial_ff : (trial_ff & ~mask_ff);

   // ***************************************************
   // Helper functions
   // ***************************************************
   // Sleep flags {light_sleep, deep_sleep} for a requested power-down depth
   function automatic logic [1:0] sleep_of(input logic depth);
      sleep_of = {~depth, depth};
   endfunction

   // Mid-scale code: first trial value and first decision mask of a conversion
   function automatic logic [RES_BITS-1:0] mid_scale();
      mid_scale = {1'b1, {(RES_BITS-1){1'b0}}};
   endfunction

   // ***************************************************
   // Next-state logic
   // ***************************************************
   always_comb begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_word   = word_ff;
      nxt_trial  = trial_ff;
      nxt_mask   = mask_ff;
      nxt_out    = out_ff;
      nxt_cfg    = cfg_ff;
      nxt_core   = core_ff;
      // Inputs are taken on rising edges and acted on at the following fall
      if (sel && rise) begin
         if (SER_IN && start_ok && state_ff != asc_pkg::ST_WORD) begin
            nxt_state = asc_pkg::ST_WORD;
            nxt_cnt   = 5'h01;
            nxt_word  = 8'h01;
         end else if (state_ff == asc_pkg::ST_WORD) begin
            nxt_word  = {word_ff[6:0], SER_IN};
            nxt_cnt   = cnt_ff + 5'h01;
         end
      end
      if (sel && fall) begin
         // A new word wakes the core from either sleep depth
         if (acq_edge) begin
            nxt_core.tracking    = 1'b1;
            nxt_core.light_sleep = 1'b0;
            nxt_core.deep_sleep  = 1'b0;
         end
         if (word_done) begin
            nxt_cfg.span_select     = full_word[asc_pkg::BIT_SPAN];
            nxt_cfg.polarity_select = full_word[asc_pkg::BIT_POLARITY];
            nxt_cfg.power_down_n    = full_word[asc_pkg::BIT_PWR_N];
            nxt_cfg.shutdown_depth  = full_word[asc_pkg::BIT_DEPTH];
            nxt_cfg.shutdown_timing = full_word[asc_pkg::BIT_TIMING];
            nxt_cfg.ref_internal    = full_word[asc_pkg::BIT_REF];
            nxt_core.tracking       = 1'b0;
            nxt_cnt                 = asc_pkg::BIT_CNT_RST;
            nxt_out                 = 1'b0;
            nxt_state               = asc_pkg::ST_CONV;
            if (imm_pd) begin
               // Immediate power-down: no conversion, result reads zero
               nxt_core.converting  = 1'b0;
               nxt_core[1:0]        = sleep_of(full_word[asc_pkg::BIT_DEPTH]);
               // Trial code stays put: no sample is held, so the DAC has nothing to do
               nxt_mask             = '0;
            end else begin
               nxt_core.converting  = 1'b1;
               nxt_mask             = mid_scale();
               nxt_trial            = mid_scale();
            end
         end else if (state_ff == asc_pkg::ST_CONV) begin
            // One decision per falling edge, MSB first, zeros after the last
            nxt_out = (mask_ff != '0) ? dec_bit : 1'b0;
            // Count saturates so a long run of trailing zeros keeps restart open
            if (cnt_ff != 5'h1F) nxt_cnt = cnt_ff + 5'h01;
            if (mask_ff != '0) begin
               nxt_mask  = mask_ff >> 1;
               nxt_trial = kept_trial | (mask_ff >> 1);
               if (mask_ff[0]) begin
                  nxt_core.converting = 1'b0;
                  // Delayed power-down takes effect once the conversion ends
                  if (!cfg_ff.power_down_n) begin
                     nxt_core[1:0] = sleep_of(cfg_ff.shutdown_depth);
                  end
               end
            end
         end
      end
   end

   // ***************************************************
   // Registers
   // ***************************************************
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_ff  <= asc_pkg::ST_IDLE;
         cnt_ff    <= asc_pkg::BIT_CNT_RST;
         word_ff   <= asc_pkg::CW_RESET;
         trial_ff  <= RES_BITS'(asc_pkg::RES_RESET);
         mask_ff   <= '0;
         out_ff    <= 1'b0;
         // Settings start from the control word's reset value: running, external reference
         cfg_ff    <= {asc_pkg::CW_RESET[6:2], asc_pkg::CW_RESET[0]};
         core_ff   <= '0;
      end else begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         word_ff   <= nxt_word;
         trial_ff  <= nxt_trial;
         mask_ff   <= nxt_mask;
         out_ff    <= nxt_out;
         cfg_ff    <= nxt_cfg;
         core_ff   <= nxt_core;
      end
   end

   // Output enable follows chip select; releasing the pin is not gated by state
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) oe_ff <= 1'b0;
      else       oe_ff <= sel;
   end

   // Every output is a register, so the pins never glitch between clock edges
   assign SER_OUT    = out_ff;
   assign SER_OUT_OE = oe_ff;
   assign SAR_TRIAL  = trial_ff;
   assign CFG        = cfg_ff;
   assign CORE       = core_ff;

endmodule // asc_port

// *** bench/asc_port_checker.sv ***
// Assertion checker for the converter serial port
`timescale 1ns/1ps
module asc_port_checker #(
   parameter int RES_BITS = 12
) (
   input wire logic                  CLK,
   input wire logic                  RSTN,
   input wire logic                  SHIFT_CLK,
   input wire logic                  CHIP_SEL_N,
   input wire logic                  SER_IN,
   input wire logic                  CMP_ABOVE,
   input wire logic                  SER_OUT,
   input wire logic                  SER_OUT_OE,
   input wire logic [RES_BITS-1:0]   SAR_TRIAL,
   input wire asc_pkg::asc_cfg_type  CFG,
   input wire asc_pkg::asc_core_type CORE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   logic       sck_ff;
   logic [4:0] falls_ff;
   logic [4:0] nxt_falls;
   // ****
   // Helper logic
   // ****
   // Falls seen while converting; cleared between conversions
   assign nxt_falls = CORE.converting ? falls_ff + {4'h0, sck_ff & !SHIFT_CLK} : 5'h00;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sck_ff   <= 1'b0;
         falls_ff <= 5'h00;
      end else begin
         sck_ff   <= SHIFT_CLK;
         falls_ff <= nxt_falls;
      end
   end
   // ****
   // Properties
   // ****
   a_oe_follows_cs: assert property ($past(RSTN) |-> SER_OUT_OE == !$past(CHIP_SEL_N))
      else $error("output enable does not follow chip select");
   a_out_on_low: assert property ($changed(SER_OUT) |-> !SHIFT_CLK)
      else $error("serial output moved while shift clock high");
   a_track_on_fall: assert property ($rose(CORE.tracking) |-> !SHIFT_CLK && !CORE.converting)
      else $error("tracking began off a falling edge");
   a_hold_after_track: assert property ($rose(CORE.converting) |-> $past(CORE.tracking) && !CORE.tracking)
      else $error("conversion did not follow tracking");
   a_trial_msb_first: assert property ($rose(CORE.converting) |-> SAR_TRIAL == {1'b1, {(RES_BITS-1){1'b0}}})
      else $error("first trial code is not mid scale");
   a_trial_quiet: assert property ($changed(SAR_TRIAL) |-> CORE.converting || $past(CORE.converting))
      else $error("trial code moved outside a conversion");
   a_bits_bounded: assert property (CORE.converting |-> int'(falls_ff) <= RES_BITS)
      else $error("conversion ran past the last result bit");
   a_cfg_on_word: assert property ($changed(CFG) |-> !SHIFT_CLK && !CHIP_SEL_N)
      else $error("settings changed outside a selected word");
   a_deep_decode: assert property (CORE.deep_sleep |-> !CFG.power_down_n && CFG.shutdown_depth && !CORE.light_sleep)
      else $error("deep sleep without its request");
   a_immediate_idle: assert property (CORE.converting |-> CFG.power_down_n || !CFG.shutdown_timing)
      else $error("conversion under immediate power-down");
endmodule // asc_port_checker
bind asc_port asc_port_checker #(.RES_BITS(RES_BITS)) u_chk (.CLK(CLK), .RSTN(RSTN),
   .SHIFT_CLK(SHIFT_CLK), .CHIP_SEL_N(CHIP_SEL_N), .SER_IN(SER_IN), .CMP_ABOVE(CMP_ABOVE),
   .SER_OUT(SER_OUT), .SER_OUT_OE(SER_OUT_OE), .SAR_TRIAL(SAR_TRIAL), .CFG(CFG), .CORE(CORE));

// *** bench/asc_host.sv ***
// Host controller model that clocks words in and results out
`timescale 1ns/1ps
module asc_host (
   input wire logic clk,
   output logic     sck,
   output logic     csn,
   output logic     sdi,
   input wire logic sdo
);
   // Shift clock stands low and device deselected outside frames
   initial begin
      sck = 1'b0;
      csn = 1'b1;
      sdi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One frame of 24 clocks, word then padding; three system clocks per half period
   task automatic xfer(input logic sel, input logic [23:0] tx, output logic [23:0] rx);
      csn = !sel;
      tick(3);
      for (int i = 23; i >= 0; i--) begin
         sdi = tx[i];
         tick(3);
         rx[i] = sdo;
         sck = 1'b1;
         tick(3);
         sck = 1'b0;
      end
      tick(3);
      csn = 1'b1;
      sdi = ~sdi; // Released line shows no stale value
      // Deselect stands a while so back-to-back frames stay apart
      tick(3);
   endtask
endmodule // asc_host

// *** bench/asc_port_test.sv ***
// Self-checking testbench of the converter serial port
`timescale 1ns/1ps
module asc_port_test;
   logic                  clk;
   logic                  rstn;
   logic                  sck;
   logic                  csn;
   logic                  sdi;
   logic                  sdo;
   logic                  oe;
   logic                  cmp;
   logic                  imm;
   logic [7:0]            cw;
   logic [11:0]           trial;
   logic [11:0]           analog_input;
   logic [11:0]           res;
   logic [23:0]           trk;
   logic [23:0]           rx;
   logic [23:0]           oes;
   asc_pkg::asc_cfg_type  cfg;
   asc_pkg::asc_core_type core;
   int                    err_total;
   int                    n_checks;
   int                    cyc;
   logic [7:0]  cw_tab [9]  = '{8'h90, 8'hF1, 8'hB0, 8'hD0, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h9D};
   logic [11:0] ain_tab [9] = '{12'hA5C, 12'h123, 12'hFFF, 12'h000, 12'h3C3, 12'h5A5,
                                12'h7FE, 12'h001, 12'h800};
   // Ideal comparator; input held as an offset-binary level
   assign cmp = (analog_input >= trial);
   asc_port dut (.CLK(clk), .RSTN(rstn), .SHIFT_CLK(sck), .CHIP_SEL_N(csn), .SER_IN(sdi),
      .CMP_ABOVE(cmp), .SER_OUT(sdo), .SER_OUT_OE(oe), .SAR_TRIAL(trial), .CFG(cfg),
      .CORE(core));
   asc_host host (.clk(clk), .sck(sck), .csn(csn), .sdi(sdi), .sdo(sdo));
   initial clk = 1'b0;
   always #25 clk = ~clk;
   // Tracking state and output enable seen at every shift clock rise
   always @(posedge sck) begin
      trk <= {trk[22:0], core.tracking};
      oes <= {oes[22:0], oe};
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Eleven frames of 153 clocks each; the ceiling leaves ample room
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         end_sim();
      end
   end
   // Main sequence
   initial begin
      rstn = 1'b0;
      analog_input = 12'h000;
      trk = 24'h0;
      err_total = 0;
      n_checks = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      chk({trial, sdo, oe, core, cfg}, 24'h000008, "reset state");
      host.xfer(1'b0, {8'hE5, 16'h0000}, rx);
      chk({oe, cfg}, 24'h000008, "deselected frame");
      chk(oes, 24'h000000, "enable while deselected");
      for (int k = 0; k < 9; k++) begin
         cw = cw_tab[k];
         analog_input = ain_tab[k];
         trk = 24'h0;
         host.xfer(1'b1, {cw, 16'h0000}, rx);
         imm = !cw[4] && cw[2];
         res = imm ? 12'h000 : (cw[5] ? analog_input ^ 12'h800 : analog_input);
         chk(rx[14:0], {res, 3'h0}, "result bits");
         chk(cfg, {cw[6:2], cw[0]}, "settings");
         chk(oes, 24'hFFFFFF, "output enable");
         chk(core[2], 1'b0, "conversion ended");
         if (cw[4]) chk(trk, 24'h0F0000, "tracking window");
         else chk(core[1:0], {!cw[3], cw[3]}, "sleep depth");
      end
      // A high bit before result bit 4 has left is data, not a new start
      host.xfer(1'b1, {8'h90, 16'h0200}, rx);
      chk(rx[14:0], {analog_input, 3'h0}, "early start ignored");
      end_sim();
   end
endmodule // asc_port_test
